// [ssmsp_regs.vh]
// register offsets, field positions and reset values of the sync serial port
`ifndef SSMSP_REGS_VH
`define SSMSP_REGS_VH

// register offsets (plain port, one byte each)
`define SSMSP_OFS_FLAGS 3'h0
`define SSMSP_OFS_ENABLES 3'h1
`define SSMSP_OFS_PRIORITY 3'h2
`define SSMSP_OFS_RXCTL 3'h3
`define SSMSP_OFS_TXBUF 3'h4
`define SSMSP_OFS_TXCTL 3'h5
`define SSMSP_OFS_BAUD 3'h6
`define SSMSP_OFS_RXBUF 3'h7

// flag and enable register fields
`define SSMSP_BIT_RXFULL 5
`define SSMSP_BIT_TXEMPTY 4

// receive control fields
`define SSMSP_BIT_PORTEN 7
`define SSMSP_BIT_RX9SEL 6
`define SSMSP_BIT_SINGLE_RX_ENABLE 5
`define SSMSP_BIT_CONTINUOUS_RX_ENABLE 4
`define SSMSP_BIT_FRAMING_ERROR 2
`define SSMSP_BIT_OVERRUN_ERROR 1
`define SSMSP_BIT_RX_NINTH_BIT 0

// transmit control fields
`define SSMSP_BIT_CSMASTER 7
`define SSMSP_BIT_TX9SEL 6
`define SSMSP_BIT_TX_ENABLE 5
`define SSMSP_BIT_SYNC 4
`define SSMSP_BIT_HISPEED 2
`define SSMSP_BIT_SRE 1
`define SSMSP_BIT_TX_NINTH_BIT 0

// reset values
`define SSMSP_RST_TXCTL 8'h02
`define SSMSP_RST_ZERO 8'h00

`endif

// [ssmsp_port.v]
// synchronous master/slave serial port, registers and shift engine
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ssmsp_regs.vh"

module ssmsp_port #(
  parameter DATA_W = 8
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // interrupt requests toward the interrupt controller
  output wire tx_irq,
  output wire rx_irq,
  // clock pin, three signals
  input wire clock_pin_in,
  output wire clock_pin_out,
  output wire clock_pin_oe,
  // data pin, three signals
  input wire data_pin_in,
  output wire data_pin_out,
  output wire data_pin_oe
);

  ////////////////////////////////////////////////////////////////////////
  // state codes
  localparam ST_IDLE = 2'd0; // nothing shifting
  localparam ST_TX = 2'd1; // shifting a word out
  localparam ST_RX = 2'd2; // shifting a word in

  ////////////////////////////////////////////////////////////////////////
  // registers seen by software
  reg [7:0] flags_r; // only bits 5 and 4 are live
  reg [7:0] enables_r; // irq enables
  reg [7:0] priority_r; // stored only, no effect here
  reg [7:0] rxctl_r; // receive control and status
  reg [7:0] txbuf_r; // transmit buffer
  reg [7:0] txctl_r; // transmit control and status
  reg [7:0] baud_r; // baud divisor
  reg [7:0] rxbuf_r; // receive buffer
  // engine state
  reg [1:0] state_r; // idle, tx or rx
  reg [DATA_W:0] shift_r; // shifter, hidden from software
  reg [3:0] bitcnt_r; // bits still to move
  reg [7:0] baud_cnt_r; // half-period counter
  reg sck_r; // master clock level
  reg txbuf_full_r; // buffer holds an unsent word
  reg dout_r; // data pin drive level
  // pin synchronisers
  reg ck_s1_r;
  reg ck_s2_r;
  reg ck_d_r; // previous synced clock, for edges
  reg dt_s1_r;
  reg dt_s2_r;

  ////////////////////////////////////////////////////////////////////////
  // decoded controls
  wire port_on = rxctl_r[`SSMSP_BIT_PORTEN] & txctl_r[`SSMSP_BIT_SYNC];
  // clear master bit, clock comes from pin
  wire master = txctl_r[`SSMSP_BIT_CSMASTER];
  wire nine_tx = txctl_r[`SSMSP_BIT_TX9SEL];
  wire nine_rx = rxctl_r[`SSMSP_BIT_RX9SEL];
  wire continuous_rx_enable = rxctl_r[`SSMSP_BIT_CONTINUOUS_RX_ENABLE];
  wire single_rx_enable = rxctl_r[`SSMSP_BIT_SINGLE_RX_ENABLE];
  wire rx_want = continuous_rx_enable | single_rx_enable;
  wire tx_enable = txctl_r[`SSMSP_BIT_TX_ENABLE];
  wire [3:0] nbits_tx = nine_tx ? 4'd9 : 4'd8;
  wire [3:0] nbits_rx = nine_rx ? 4'd9 : 4'd8;
  wire wr_txbuf = reg_wr & (reg_addr == `SSMSP_OFS_TXBUF);
  wire wr_rxctl = reg_wr & (reg_addr == `SSMSP_OFS_RXCTL);

  ////////////////////////////////////////////////////////////////////////
  // shift clock edges: master makes them, slave finds them on the pin
  // half period is divisor plus one cycles
  wire tick = (baud_cnt_r == baud_r);
  wire run = (state_r != ST_IDLE);
  wire m_rise = master & run & tick & ~sck_r;
  wire m_fall = master & run & tick & sck_r;
  // slave edges come from the pin, no internal timer
  wire s_rise = ~master & ck_s2_r & ~ck_d_r;
  wire s_fall = ~master & ~ck_s2_r & ck_d_r;
  wire rise = m_rise | s_rise;
  wire fall = m_fall | s_fall;

  // pin drive: master owns clock, only when port on
  assign clock_pin_oe = port_on & master;
  assign clock_pin_out = sck_r;
  // data pin is driven only while transmitting
  assign data_pin_oe = port_on & (state_r == ST_TX);
  assign data_pin_out = dout_r;

  // transmit request gated by its enable
  assign tx_irq = flags_r[`SSMSP_BIT_TXEMPTY] &
                  enables_r[`SSMSP_BIT_TXEMPTY];
  // receive request gated by its enable
  assign rx_irq = flags_r[`SSMSP_BIT_RXFULL] & enables_r[`SSMSP_BIT_RXFULL];

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for both pins
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_d_r <= 1'b0;
      dt_s1_r <= 1'b0;
      dt_s2_r <= 1'b0;
    end else begin
      ck_s1_r <= clock_pin_in;
      ck_s2_r <= ck_s1_r;
      ck_d_r <= ck_s2_r;
      dt_s1_r <= data_pin_in;
      dt_s2_r <= dt_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // master baud timer, free only while a word is moving
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_cnt_r <= 8'h00;
      sck_r <= 1'b0;
    end else if (!run || !master) begin
      // idle level low keeps the partner quiet
      baud_cnt_r <= 8'h00;
      sck_r <= 1'b0;
    end else if (tick) begin
      baud_cnt_r <= 8'h00;
      sck_r <= ~sck_r;
    end else begin
      baud_cnt_r <= baud_cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shift engine and all software registers
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= `SSMSP_RST_ZERO;
      enables_r <= `SSMSP_RST_ZERO;
      priority_r <= `SSMSP_RST_ZERO;
      rxctl_r <= `SSMSP_RST_ZERO;
      txbuf_r <= `SSMSP_RST_ZERO;
      txctl_r <= `SSMSP_RST_TXCTL;
      baud_r <= `SSMSP_RST_ZERO;
      rxbuf_r <= `SSMSP_RST_ZERO;
      state_r <= ST_IDLE;
      shift_r <= {(DATA_W+1){1'b0}};
      bitcnt_r <= 4'd0;
      txbuf_full_r <= 1'b0;
      dout_r <= 1'b0;
    end else begin
      // software writes; status bits are masked off below
      if (reg_wr) begin
        if (reg_addr == `SSMSP_OFS_FLAGS) begin
          flags_r[`SSMSP_BIT_RXFULL] <= flags_r[`SSMSP_BIT_RXFULL];
        end else if (reg_addr == `SSMSP_OFS_ENABLES) begin
          enables_r <= reg_wdata;
        end else if (reg_addr == `SSMSP_OFS_PRIORITY) begin
          priority_r <= reg_wdata;
        end else if (reg_addr == `SSMSP_OFS_RXCTL) begin
          // error and ninth bits are hardware owned
          rxctl_r[7:3] <= reg_wdata[7:3];
        end else if (reg_addr == `SSMSP_OFS_TXBUF) begin
          txbuf_r <= reg_wdata;
        end else if (reg_addr == `SSMSP_OFS_TXCTL) begin
          txctl_r[7:4] <= reg_wdata[7:4];
          txctl_r[2] <= reg_wdata[2];
          txctl_r[0] <= reg_wdata[0];
        end else if (reg_addr == `SSMSP_OFS_BAUD) begin
          baud_r <= reg_wdata;
        end
      end
      // dropping continuous enable clears error state
      if (wr_rxctl && !reg_wdata[`SSMSP_BIT_CONTINUOUS_RX_ENABLE]) begin
        rxctl_r[`SSMSP_BIT_FRAMING_ERROR] <= 1'b0;
        rxctl_r[`SSMSP_BIT_OVERRUN_ERROR] <= 1'b0;
      end
      // a buffer write arms a transmission
      if (wr_txbuf) begin
        txbuf_full_r <= 1'b1;
        // only a buffer write clears the empty flag
        flags_r[`SSMSP_BIT_TXEMPTY] <= 1'b0;
      end
      // reading the receive buffer frees it
      if (reg_rd && reg_addr == `SSMSP_OFS_RXBUF) begin
        flags_r[`SSMSP_BIT_RXFULL] <= 1'b0;
      end
      // port off, or transmit disabled while in tx: abandon shifting, shifter is empty
      if (!port_on || (!tx_enable && state_r == ST_TX)) begin
        state_r <= ST_IDLE;
        txctl_r[`SSMSP_BIT_SRE] <= 1'b1;
      end
      if (!tx_enable) begin
        txbuf_full_r <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          // transmit only when no receive requested
          if (port_on && tx_enable && txbuf_full_r && !wr_txbuf && !rx_want) begin
            // one-cycle move, buffer empty, flag set
            shift_r <= {txctl_r[`SSMSP_BIT_TX_NINTH_BIT], txbuf_r};
            bitcnt_r <= nbits_tx;
            txbuf_full_r <= 1'b0;
            flags_r[`SSMSP_BIT_TXEMPTY] <= 1'b1;
            txctl_r[`SSMSP_BIT_SRE] <= 1'b0;
            dout_r <= txbuf_r[0];
            state_r <= ST_TX;
          end else if (port_on && rx_want && !txbuf_full_r) begin
            bitcnt_r <= nbits_rx;
            state_r <= ST_RX;
          end
        end
        ST_TX: begin
          // data changes on the rising edge, partner samples falling
          if (fall) begin
            bitcnt_r <= bitcnt_r - 4'd1;
            shift_r <= {1'b0, shift_r[DATA_W:1]};
          end
          // every rising edge presents the current low bit; this also
          // puts bit 0 of a chained word out, since the chain reloads
          // the shifter at the falling edge without touching the pin
          if (rise) begin
            dout_r <= shift_r[0];
          end
          if (fall && bitcnt_r == 4'd1) begin
            // last bit gone; chain next word if present
            if (txbuf_full_r && tx_enable && !wr_txbuf) begin
              shift_r <= {txctl_r[`SSMSP_BIT_TX_NINTH_BIT], txbuf_r};
              bitcnt_r <= nbits_tx;
              txbuf_full_r <= 1'b0;
              flags_r[`SSMSP_BIT_TXEMPTY] <= 1'b1;
            end else begin
              txctl_r[`SSMSP_BIT_SRE] <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
        end
        ST_RX: begin
          // sample data on falling shift clock
          if (fall) begin
            shift_r <= {dt_s2_r, shift_r[DATA_W:1]};
            bitcnt_r <= bitcnt_r - 4'd1;
          end
          if (fall && bitcnt_r == 4'd1) begin
            // word complete sets the full flag
            flags_r[`SSMSP_BIT_RXFULL] <= 1'b1;
            if (flags_r[`SSMSP_BIT_RXFULL]) begin
              // unread word: keep old data, flag overrun
              rxctl_r[`SSMSP_BIT_OVERRUN_ERROR] <= 1'b1;
            end else if (nine_rx) begin
              rxbuf_r <= shift_r[DATA_W:1];
              // ninth bit captured with the word
              rxctl_r[`SSMSP_BIT_RX_NINTH_BIT] <= dt_s2_r;
            end else begin
              rxbuf_r <= {dt_s2_r, shift_r[DATA_W:2]};
            end
            if (continuous_rx_enable && !(wr_rxctl && !reg_wdata[`SSMSP_BIT_CONTINUOUS_RX_ENABLE])) begin
              bitcnt_r <= nbits_rx;
            end else begin
              // single word then single enable drops
              rxctl_r[`SSMSP_BIT_SINGLE_RX_ENABLE] <= 1'b0;
              state_r <= ST_IDLE;
            end
          end else if (!rx_want) begin
            // enables dropped mid-word: stop receiving
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe, zero otherwise
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == `SSMSP_OFS_FLAGS) begin
      reg_rdata <= flags_r;
    end else if (reg_addr == `SSMSP_OFS_ENABLES) begin
      reg_rdata <= enables_r;
    end else if (reg_addr == `SSMSP_OFS_PRIORITY) begin
      reg_rdata <= priority_r;
    end else if (reg_addr == `SSMSP_OFS_RXCTL) begin
      reg_rdata <= rxctl_r;
    end else if (reg_addr == `SSMSP_OFS_TXBUF) begin
      reg_rdata <= txbuf_r;
    end else if (reg_addr == `SSMSP_OFS_TXCTL) begin
      // only control and status, bit 3 reads zero, never the shifter
      reg_rdata <= {txctl_r[7:4], 1'b0, txctl_r[2:0]};
    end else if (reg_addr == `SSMSP_OFS_BAUD) begin
      reg_rdata <= baud_r;
    end else begin
      reg_rdata <= rxbuf_r;
    end
  end

endmodule
`default_nettype wire

// [ssmsp_port_assertions.sv]
// checker for the sync serial port pins and register port
`timescale 1ns/1ps
`default_nettype none
`include "ssmsp_regs.vh"
module ssmsp_port_assertions (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // requests and pins
  input wire logic tx_irq,
  input wire logic rx_irq,
  input wire logic clock_pin_in,
  input wire logic clock_pin_out,
  input wire logic clock_pin_oe,
  input wire logic data_pin_in,
  input wire logic data_pin_out,
  input wire logic data_pin_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] rx_r, tx_r, en_r, baud_r; // shadows of software writes
  logic tx_wr_r; // transmit control written since reset
  logic [8:0] hi_r; // cycles the master clock has stood high
  // shadows let pin checks follow settings without seeing the bodies
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_r <= 8'h00;
      tx_r <= 8'h02;
      en_r <= 8'h00;
      baud_r <= 8'h00;
      tx_wr_r <= 1'b0;
      hi_r <= 9'h000;
    end else begin
      if (reg_wr && reg_addr == `SSMSP_OFS_RXCTL) rx_r <= reg_wdata;
      if (reg_wr && reg_addr == `SSMSP_OFS_TXCTL) tx_r <= reg_wdata;
      if (reg_wr && reg_addr == `SSMSP_OFS_TXCTL) tx_wr_r <= 1'b1;
      if (reg_wr && reg_addr == `SSMSP_OFS_ENABLES) en_r <= reg_wdata;
      if (reg_wr && reg_addr == `SSMSP_OFS_BAUD) baud_r <= reg_wdata;
      hi_r <= clock_pin_out ? hi_r + 9'h001 : 9'h000;
    end
  end
  wire port_on = rx_r[7] && tx_r[4]; // pins claimed by the port
  ////////////////////////////////////////////////////////////////////////
  AST_TX_IRQ_GATE: assert property (
    tx_irq |-> en_r[`SSMSP_BIT_TXEMPTY])
    else $error("tx request while its enable is clear");
  AST_TX_FLAG_HOLD: assert property (
    $fell(tx_irq) |-> $past(reg_wr) && ($past(reg_addr) == 3'h4
      || $past(reg_addr) == 3'h1))
    else $error("tx empty request dropped without a buffer write");
  AST_RX_IRQ_GATE: assert property (
    rx_irq |-> en_r[`SSMSP_BIT_RXFULL])
    else $error("rx request while its enable is clear");
  AST_TXCTL_RESET: assert property (
    reg_rd && reg_addr == `SSMSP_OFS_TXCTL && !tx_wr_r
      |=> reg_rdata == `SSMSP_RST_TXCTL)
    else $error("transmit control differs from its reset value");
  AST_CLK_OE: assert property (
    clock_pin_oe == (port_on && tx_r[`SSMSP_BIT_CSMASTER]))
    else $error("clock pin drive does not follow master select");
  AST_DATA_OE: assert property (
    data_pin_oe |-> port_on)
    else $error("data pin driven while the port is off");
  AST_SHIFT_REG_EMPTY_BUSY: assert property (
    reg_rd && reg_addr == `SSMSP_OFS_TXCTL && data_pin_oe
      |=> !reg_rdata[`SSMSP_BIT_SRE])
    else $error("shifter empty reads set while shifting");
  AST_HALF_PERIOD: assert property (
    $fell(clock_pin_out) && clock_pin_oe && !$past(reg_wr)
      && !$past(reg_wr, 2) |-> hi_r == {1'b0, baud_r} + 9'h001)
    else $error("master clock high time differs from divisor");
  cover property ($rose(tx_irq));
  cover property ($rose(rx_irq));
  cover property ($fell(data_pin_oe));
endmodule
bind ssmsp_port ssmsp_port_assertions u_chk (.sys_clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_irq, .rx_irq, .clock_pin_in,
  .clock_pin_out, .clock_pin_oe, .data_pin_in, .data_pin_out, .data_pin_oe);
`default_nettype wire

// [ssmsp_far_end.sv]
// far-end model: a synchronous serial partner on the clock and data pins
`timescale 1ns/1ps
`default_nettype none
module ssmsp_far_end (
  // resolved pin levels
  input wire logic ck_line,
  input wire logic dt_line,
  // partner drive toward the pins
  output var logic ck_drive,
  output var logic dt_drive
);
  logic [7:0] tx_word = 8'h00; // word sent to the device
  logic [8:0] got = 9'h000; // bits seen from the device, newest on top
  int falls = 0; // falling clock edges since the last arm
  logic drv_en = 1'b0; // partner presents its word
  initial ck_drive = 1'b0;
  initial dt_drive = 1'b0;
  always @(negedge ck_line) begin
    got <= {dt_line, got[8:1]};
    falls <= falls + 1;
  end
  // change after rise
  // off its word the line toggles, so a stale level never passes
  always @(posedge ck_line) begin
    if (drv_en) dt_drive <= tx_word[falls[2:0]];
    else dt_drive <= ~dt_drive;
  end
  // load a word and show its first bit before the first rise
  task automatic arm(input logic [7:0] w);
    tx_word = w;
    falls = 0;
    dt_drive = w[0];
    drv_en = 1'b1;
  endtask
  // external clock, only within a frame, phase unrelated
  task automatic slave_clocks(input int n);
    #7;
    repeat (n) begin
      #80 ck_drive = 1'b1;
      #80 ck_drive = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [ssmsp_port_test.sv]
// self-checking bench for the sync serial port
`timescale 1ns/1ps
`default_nettype none
`include "ssmsp_regs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module ssmsp_port_test;
  localparam logic [2:0] A_FLG = `SSMSP_OFS_FLAGS, A_EN = `SSMSP_OFS_ENABLES;
  localparam logic [2:0] A_RXC = `SSMSP_OFS_RXCTL, A_TXB = `SSMSP_OFS_TXBUF;
  localparam logic [2:0] A_TXC = `SSMSP_OFS_TXCTL, A_RXB = `SSMSP_OFS_RXBUF;
  logic sys_clk, rst_n, reg_wr, reg_rd; // bench-driven inputs
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, rd_v;
  wire [7:0] reg_rdata;
  wire tx_irq, rx_irq, ck_out, ck_oe, dt_out, dt_oe, ck_drv, dt_drv;
  // each pin level resolved from both parties' drive
  wire ck_line = ck_oe ? ck_out : ck_drv;
  wire dt_line = dt_oe ? dt_out : dt_drv;
  int bad_count = 0;
  int tests_run = 0;
  ssmsp_port DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_irq(tx_irq), .rx_irq(rx_irq),
    .clock_pin_in(ck_line), .clock_pin_out(ck_out), .clock_pin_oe(ck_oe),
    .data_pin_in(dt_line), .data_pin_out(dt_out), .data_pin_oe(dt_oe));
  ssmsp_far_end far (.ck_line(ck_line), .dt_line(dt_line),
    .ck_drive(ck_drv), .dt_drive(dt_drv));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // one write, then an idle edge so strobes never collide
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
    rd(a, rd_v);
    `CHK(rd_v, e);
  endtask
  // polls a status bit; bounded so a stuck flag cannot hang the run
  task automatic wait_bit(input logic [2:0] a, input int b, input logic v);
    int k;
    k = 0;
    rd(a, rd_v);
    while (rd_v[b] !== v && k < 300) begin
      rd(a, rd_v);
      k++;
    end
    `CHK(rd_v[b], v);
  endtask
  task automatic wait_falls(input int n);
    int k;
    k = 0;
    while (far.falls < n && k < 500) begin
      @(posedge sys_clk);
      k++;
    end
    `CHK(far.falls, n);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      chk_rd(3'(i), (i == 5) ? `SSMSP_RST_TXCTL : `SSMSP_RST_ZERO);
    end
  endtask
  task automatic t_tx_master();
    wr(`SSMSP_OFS_BAUD, 8'h02);
    wr(A_RXC, 8'h80);
    wr(A_TXC, 8'h90);
    wr(A_TXC, 8'hB0);
    far.falls = 0;
    wr(A_TXB, 8'hA5);
    repeat (3) @(posedge sys_clk);
    wr(A_TXB, 8'h3C);
    chk_rd(A_FLG, 8'h00);
    chk_rd(A_TXC, 8'hB0);
    wait_falls(8);
    `CHK(far.got[8:1], 8'hA5);
    wait_bit(A_FLG, 4, 1'b1);
    wait_bit(A_TXC, 1, 1'b1);
    `CHK(far.got[8:1], 8'h3C);
    `CHK(tx_irq, 1'b0);
    wr(A_EN, 8'h10);
    `CHK(tx_irq, 1'b1);
    wr(A_FLG, 8'h00);
    chk_rd(A_FLG, 8'h10);
    wr(A_EN, 8'h00);
  endtask
  task automatic t_rx_single();
    wr(A_TXC, 8'h90);
    wr(A_RXC, 8'h80);
    far.arm(8'h5A);
    wr(A_RXC, 8'hA0);
    wait_bit(A_FLG, 5, 1'b1);
    `CHK(rx_irq, 1'b0);
    chk_rd(A_RXC, 8'h80);
    chk_rd(A_RXB, 8'h5A);
    repeat (100) @(posedge sys_clk);
    `CHK(far.falls, 8);
  endtask
  task automatic t_rx_cont();
    wr(A_EN, 8'h20);
    far.arm(8'hC3);
    wr(A_RXC, 8'hB0);
    wait_bit(A_FLG, 5, 1'b1);
    `CHK(rx_irq, 1'b1);
    chk_rd(A_RXB, 8'hC3);
    wait_bit(A_FLG, 5, 1'b1);
    // one word lasts 16 half periods of 3 cycles; let a third land
    repeat (60) @(posedge sys_clk);
    rd(A_RXC, rd_v);
    `CHK(rd_v & 8'h92, 8'h92);
    wr(A_RXC, 8'h80);
    chk_rd(A_RXC, 8'h80);
    chk_rd(A_RXB, 8'hC3);
    wr(A_EN, 8'h00);
  endtask
  task automatic t_slave_tx9();
    far.drv_en = 1'b0;
    far.falls = 0;
    wr(A_TXC, 8'h71);
    `CHK(ck_oe, 1'b0);
    wr(A_TXB, 8'h96);
    far.slave_clocks(9);
    repeat (8) @(posedge sys_clk);
    `CHK(far.got, 9'h196);
    chk_rd(A_TXC, 8'h73);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_tx_master();
    t_rx_single();
    t_rx_cont();
    t_slave_tx9();
    conclude();
  end
  // whole run needs well under a thousand cycles; this is far beyond it
  initial begin
    #1_000_000;
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
